// File: rtl/pior_pkg.sv
// constants, register offsets and field layouts of the peripheral register area.
// assumes a cpu core that issues 1-, 4- and 8-bit accesses on 12-bit addresses.
//
// Contract
// RL1 - the status word takes 1-bit and 4-bit reads and writes, but an 8-bit access only reads it.
// RL2 - the second edge mode register keeps only bit 0 and reads its upper three bits as zero.
// RL3 - the third edge mode register keeps bits 1 and 0 and reads its upper two bits as zero.
// RL4 - the global enable and disable instructions touch only bit 3 of the priority register.
// RL5 - the standby instructions may set bits 3 and 2 of the clock control register one by one.
// RL6 - each interrupt source has one enable flag and one request flag, each readable and writable alone.
// RL7 - the counter 1 output enable flag is write-only and set or cleared by single-bit writes.
// RL8 - read/write locations return their value, read-only ones ignore writes, write-only ones read zero.
// RL9 - unmapped addresses in the area read zero and ignore writes.
package pior_pkg;
    typedef enum logic [2:0] {
        PIOR_SZ_BIT = 3'b001,
        PIOR_SZ_NIB = 3'b010,
        PIOR_SZ_BYTE = 3'b100
    } pior_size_type;

    localparam logic [11:0] PIOR_AREA_LO = 12'hf80;
    localparam logic [11:0] PIOR_OFS_CNT1_OE = 12'hfaa;
    localparam logic [11:0] PIOR_OFS_STATUS = 12'hfb0;
    localparam logic [11:0] PIOR_OFS_PRIO = 12'hfb2;
    localparam logic [11:0] PIOR_OFS_CLKCTL = 12'hfb3;
    localparam logic [11:0] PIOR_OFS_EDGE0 = 12'hfb4;
    localparam logic [11:0] PIOR_OFS_EDGE1 = 12'hfb5;
    localparam logic [11:0] PIOR_OFS_EDGE2 = 12'hfb6;
    localparam logic [11:0] PIOR_OFS_IRQA = 12'hfb8;
    localparam logic [11:0] PIOR_OFS_IRQE = 12'hfba;
    localparam logic [11:0] PIOR_OFS_IRQF = 12'hfbd;
    localparam logic [11:0] PIOR_OFS_IRQG = 12'hfbe;
    localparam logic [11:0] PIOR_OFS_IRQH = 12'hfbf;
    localparam logic [11:0] PIOR_OFS_BITSEQ0 = 12'hfc0;
    localparam logic [11:0] PIOR_OFS_CLKOUT = 12'hfd0;
    localparam logic [11:0] PIOR_OFS_PUA = 12'hfdc;
    localparam logic [11:0] PIOR_OFS_PUB = 12'hfde;
    localparam logic [11:0] PIOR_OFS_SER_MODE = 12'hfe0;
    localparam logic [11:0] PIOR_OFS_SBUS_CTRL = 12'hfe2;
    localparam logic [11:0] PIOR_OFS_SHIFT = 12'hfe4;
    localparam logic [11:0] PIOR_OFS_SLV_ADDR = 12'hfe6;
    localparam logic [11:0] PIOR_OFS_PMA = 12'hfe8;
    localparam logic [11:0] PIOR_OFS_PMB = 12'hfec;
    localparam logic [11:0] PIOR_OFS_PMC = 12'hfee;
    localparam logic [11:0] PIOR_OFS_PDATA0 = 12'hff0;
    localparam logic [11:0] PIOR_OFS_PDATA1 = 12'hff1;
    localparam logic [11:0] PIOR_OFS_PDATA2 = 12'hff2;
    localparam logic [11:0] PIOR_OFS_PDATA3 = 12'hff3;
    localparam logic [11:0] PIOR_OFS_PDATA5 = 12'hff5;
    localparam logic [11:0] PIOR_OFS_PDATA6 = 12'hff6;
    localparam logic [11:0] PIOR_OFS_PDATA7 = 12'hff7;
    localparam logic [11:0] PIOR_OFS_PDATA8 = 12'hff8;

    localparam logic [3:0] PIOR_EDGE1_MASK = 4'h1;
    localparam logic [3:0] PIOR_EDGE2_MASK = 4'h3;
    localparam logic [3:0] PIOR_NIB_ONES = 4'hf;
    localparam logic [3:0] PIOR_NIB_ZERO = 4'h0;
    localparam logic [7:0] PIOR_BYTE_ZERO = 8'h00;
    localparam logic [3:0] PIOR_NIB_RESET = 4'h0;
    localparam logic [7:0] PIOR_BYTE_RESET = 8'h00;
    localparam int PIOR_PRIO_GIE_BIT = 3;
    localparam int PIOR_CLK_STOP_BIT = 3;
    localparam int PIOR_CLK_HALT_BIT = 2;
    localparam int PIOR_NUM_NIB = 4096;
endpackage

// File: rtl/pior_acc_if.sv
// access carrier between the register bank and its lane merge helper.
// assumes one access per clock, decoded by the top module.
`timescale 1ns/100ps
interface pior_acc_if;
    import pior_pkg::*;
    logic [3:0] old_nib;
    logic [1:0] bit_sel;
    logic bit_val;
    logic [3:0] nib_val;
    pior_size_type size;
    logic [3:0] new_nib;
    modport bank (output old_nib, output bit_sel, output bit_val, output nib_val, output size, input new_nib);
    modport merge (input old_nib, input bit_sel, input bit_val, input nib_val, input size, output new_nib);
endinterface

// File: rtl/pior_nib_merge.sv
// merges a 1-bit or 4-bit write into one stored nibble.
// assumes the caller only uses the result on a write to that nibble.
`timescale 1ns/100ps
module pior_nib_merge
    import pior_pkg::*;
(
    pior_acc_if.merge acc
);
    always_comb begin
        acc.new_nib = acc.old_nib;
        case (acc.size)
            PIOR_SZ_BIT: acc.new_nib[acc.bit_sel] = acc.bit_val;
            PIOR_SZ_NIB: acc.new_nib = acc.nib_val;
            default: acc.new_nib = acc.old_nib;
        endcase
    end
endmodule

// File: rtl/pior_bank.sv
// peripheral register bank: storage, access rules and read mux of the i/o area.
// assumes the cpu holds addr/size/data stable while wr_i or rd_i is high for one cycle.
// 8-bit accesses use the even address; byte [3:0] is that nibble, [7:4] the next.
`timescale 1ns/100ps
module pior_bank
    import pior_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] addr_i,
    input wire logic [2:0] size_i,
    input wire logic [1:0] bit_sel_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic global_irq_enable_instr_i,
    input wire logic global_irq_disable_instr_i,
    input wire logic stop_instr_i,
    input wire logic halt_instr_i,
    input wire logic [3:0] port_data0_pins_i,
    input wire logic [3:0] port_data1_pins_i,
    input wire logic [3:0] status_flags_hi_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [3:0] interrupt_priority_select_o,
    output logic [3:0] processor_clock_control_o,
    output logic [3:0] status_word_lo_o,
    output logic counter1_output_enable_o,
    output logic [19:0] irq_flags_o
);
    // nibble storage indexed by (addr - 0xf80); only mapped slots are written
    localparam int NSLOT = 128;
    logic [3:0] nib_reg [NSLOT];
    logic cnt1_oe_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [3:0] merged;
    logic [6:0] idx;
    logic [3:0] rd_lo;
    logic [3:0] rd_hi;
    pior_size_type sz;

    pior_acc_if acc();
    pior_nib_merge u_merge (.acc(acc));

    function automatic logic [6:0] slot(input logic [11:0] a);
        logic [11:0] d;
        d = a - PIOR_AREA_LO;
        return d[6:0];
    endfunction

    // readable-and-writable nibble slot check
    function automatic logic is_rw(input logic [11:0] a);
        case (a)
            PIOR_OFS_STATUS, PIOR_OFS_PRIO, PIOR_OFS_CLKCTL, PIOR_OFS_EDGE0, PIOR_OFS_EDGE1, PIOR_OFS_EDGE2,
            PIOR_OFS_IRQA, PIOR_OFS_IRQE, PIOR_OFS_IRQF, PIOR_OFS_IRQG, PIOR_OFS_IRQH,
            PIOR_OFS_BITSEQ0, PIOR_OFS_BITSEQ0 + 12'h001, PIOR_OFS_BITSEQ0 + 12'h002, PIOR_OFS_BITSEQ0 + 12'h003,
            PIOR_OFS_CLKOUT, PIOR_OFS_PDATA2, PIOR_OFS_PDATA3, PIOR_OFS_PDATA5, PIOR_OFS_PDATA6,
            PIOR_OFS_PDATA7, PIOR_OFS_PDATA8,
            PIOR_OFS_PUA, PIOR_OFS_PUA + 12'h001, PIOR_OFS_PUB, PIOR_OFS_PUB + 12'h001,
            PIOR_OFS_SHIFT, PIOR_OFS_SHIFT + 12'h001, PIOR_OFS_SLV_ADDR, PIOR_OFS_SLV_ADDR + 12'h001,
            PIOR_OFS_PMA, PIOR_OFS_PMA + 12'h001, PIOR_OFS_PMB, PIOR_OFS_PMB + 12'h001,
            PIOR_OFS_PMC, PIOR_OFS_PMC + 12'h001: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic is_wo(input logic [11:0] a);
        case (a)
            PIOR_OFS_SER_MODE, PIOR_OFS_SER_MODE + 12'h001, PIOR_OFS_SBUS_CTRL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic [3:0] keep_mask(input logic [11:0] a);
        case (a)
            PIOR_OFS_EDGE1: return PIOR_EDGE1_MASK;
            PIOR_OFS_EDGE2: return PIOR_EDGE2_MASK;
            default: return PIOR_NIB_ONES;
        endcase
    endfunction

    // value seen by a read of one nibble
    function automatic logic [3:0] rd_nib(input logic [11:0] a, input logic [3:0] stored,
                                          input logic [3:0] p0, input logic [3:0] p1);
        if (a == PIOR_OFS_PDATA0) begin
            return p0;
        end else if (a == PIOR_OFS_PDATA1) begin
            return p1;
        end else if (is_rw(a)) begin
            return stored & keep_mask(a);
        end
        return PIOR_NIB_ZERO;
    endfunction

    assign sz = pior_size_type'(size_i);
    assign idx = slot(addr_i);
    assign acc.old_nib = nib_reg[idx];
    assign acc.bit_sel = bit_sel_i;
    assign acc.bit_val = wdata_i[0];
    assign acc.nib_val = wdata_i[3:0];
    assign acc.size = sz;
    assign merged = acc.new_nib & keep_mask(addr_i);

    // per-slot storage; write rules resolve inside the decode
    generate
        for (genvar g = 0; g < NSLOT; g++) begin : g_slot
            localparam logic [11:0] A = PIOR_AREA_LO + 12'(g);
            localparam logic [11:0] AE = {A[11:1], 1'b0};
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    nib_reg[g] <= PIOR_NIB_RESET;
                end else if (A == PIOR_OFS_PRIO && (global_irq_enable_instr_i || global_irq_disable_instr_i)) begin
                    // RL4 enable bit only
                    nib_reg[g][PIOR_PRIO_GIE_BIT] <= global_irq_enable_instr_i;
                end else if (A == PIOR_OFS_CLKCTL && (stop_instr_i || halt_instr_i)) begin
                    // RL5 standby bit sets
                    if (stop_instr_i) begin
                        nib_reg[g][PIOR_CLK_STOP_BIT] <= 1'b1;
                    end
                    if (halt_instr_i) begin
                        nib_reg[g][PIOR_CLK_HALT_BIT] <= 1'b1;
                    end
                end else if (wr_i && (is_rw(A) || is_wo(A))) begin
                    // RL1 status byte writes ignored
                    if (sz == PIOR_SZ_BYTE && A != PIOR_OFS_STATUS && A != PIOR_OFS_STATUS + 12'h001) begin
                        if (addr_i == AE && A != AE + 12'h001) begin
                            nib_reg[g] <= wdata_i[3:0];
                        end else if (addr_i == AE && A == AE + 12'h001) begin
                            nib_reg[g] <= wdata_i[7:4];
                        end
                    end else if (sz != PIOR_SZ_BYTE && addr_i == A) begin
                        // RL2 RL3 RL6 masked nibble and bit writes
                        nib_reg[g] <= merged;
                    end
                end
            end
        end
    endgenerate

    // RL7 write-only single-bit flag
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt1_oe_reg <= 1'b0;
        end else if (wr_i && sz == PIOR_SZ_BIT && addr_i == PIOR_OFS_CNT1_OE) begin
            cnt1_oe_reg <= wdata_i[0];
        end
    end

    // value of the addressed nibble and of the one above it
    assign rd_lo = rd_nib(addr_i, nib_reg[idx], port_data0_pins_i, port_data1_pins_i);
    assign rd_hi = rd_nib(addr_i + 12'h001, nib_reg[7'(idx + 7'h01)], port_data0_pins_i, port_data1_pins_i);

    // RL8 RL9 read mux, write-only and unmapped read zero
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_reg <= PIOR_BYTE_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd_i;
            if (!rd_i) begin
                rdata_reg <= PIOR_BYTE_ZERO;
            end else if (sz == PIOR_SZ_BYTE && addr_i == PIOR_OFS_STATUS) begin
                // RL1 byte read carries cpu flags
                rdata_reg <= {status_flags_hi_i, rd_lo};
            end else if (sz == PIOR_SZ_BYTE) begin
                rdata_reg <= {rd_hi, rd_lo};
            end else if (sz == PIOR_SZ_BIT) begin
                rdata_reg <= {7'h00, rd_lo[bit_sel_i]};
            end else begin
                rdata_reg <= {PIOR_NIB_ZERO, rd_lo};
            end
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign interrupt_priority_select_o = nib_reg[slot(PIOR_OFS_PRIO)];
    assign processor_clock_control_o = nib_reg[slot(PIOR_OFS_CLKCTL)];
    assign status_word_lo_o = nib_reg[slot(PIOR_OFS_STATUS)];
    assign counter1_output_enable_o = cnt1_oe_reg;
    assign irq_flags_o = {nib_reg[slot(PIOR_OFS_IRQH)], nib_reg[slot(PIOR_OFS_IRQG)],
                          nib_reg[slot(PIOR_OFS_IRQF)], nib_reg[slot(PIOR_OFS_IRQE)],
                          nib_reg[slot(PIOR_OFS_IRQA)]};

    chk_status_byte_ro: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_i && sz == PIOR_SZ_BYTE && addr_i == PIOR_OFS_STATUS) |=> $stable(status_word_lo_o)) // RL1
        else $error("status word changed by byte write");
    chk_edge1_upper_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_i && sz == PIOR_SZ_NIB && addr_i == PIOR_OFS_EDGE1) |=> rdata_o[3:1] == 3'h0) // RL2
        else $error("edge mode 1 upper bits not zero");
    chk_edge2_upper_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_i && sz == PIOR_SZ_NIB && addr_i == PIOR_OFS_EDGE2) |=> rdata_o[3:2] == 2'h0) // RL3
        else $error("edge mode 2 upper bits not zero");
    chk_gie_only_top: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        global_irq_enable_instr_i |=> interrupt_priority_select_o[3] && $stable(interrupt_priority_select_o[2:0])) // RL4
        else $error("enable instruction touched wrong bits");
    chk_stop_sets_clk: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        stop_instr_i |=> processor_clock_control_o[3]) // RL5
        else $error("stop did not set clock control bit 3");
    chk_irq_bit_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_i && sz == PIOR_SZ_BIT && addr_i == PIOR_OFS_IRQA) |=> irq_flags_o[$past(bit_sel_i)] == $past(wdata_i[0])) // RL6
        else $error("irq flag bit write lost");
    chk_oe_bit_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (wr_i && sz == PIOR_SZ_BIT && addr_i == PIOR_OFS_CNT1_OE) |=> counter1_output_enable_o == $past(wdata_i[0])) // RL7
        else $error("output enable flag not written");
    chk_wo_reads_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_i && addr_i == PIOR_OFS_SBUS_CTRL) |=> rvalid_o && rdata_o == 8'h00) // RL8
        else $error("write-only location returned data");
    chk_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (rd_i && sz == PIOR_SZ_NIB && addr_i == PIOR_OFS_STATUS + 12'h001) |=> rdata_o == 8'h00) // RL9
        else $error("unmapped read not zero");
    cov_status_byte_read: cover property (@(posedge ref_clk_i) rd_i && sz == PIOR_SZ_BYTE && addr_i == PIOR_OFS_STATUS);
    cov_enable_then_disable: cover property (@(posedge ref_clk_i)
        global_irq_enable_instr_i ##1 global_irq_disable_instr_i);
    cov_halt: cover property (@(posedge ref_clk_i) halt_instr_i);
endmodule

// File: tb/tb_top.sv
// self-checking bench for the peripheral register bank, one task a scenario.
// assumes the bank answers reads one cycle after rd_i and applies writes at once.
`timescale 1ns/100ps
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin err_count++; $display("mismatch t=%0t got %h exp %h", $time, act, exp); end end
module tb_top
    import pior_pkg::*;
;
    logic ref_clk_i, reset_i, wr_i, rd_i, gie_i, gdi_i, stop_i, halt_i, rvalid_o, oe_o;
    logic [11:0] addr_i;
    logic [2:0] size_i;
    logic [1:0] bit_sel_i;
    logic [7:0] wdata_i, rdata_o;
    logic [3:0] pd0_i, pd1_i, sw_hi_i, prio_o, clkc_o, sw_lo_o;
    logic [19:0] irq_flags_o;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    pior_bank dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .size_i(size_i),
        .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .global_irq_enable_instr_i(gie_i), .global_irq_disable_instr_i(gdi_i),
        .stop_instr_i(stop_i), .halt_instr_i(halt_i), .port_data0_pins_i(pd0_i), .port_data1_pins_i(pd1_i),
        .status_flags_hi_i(sw_hi_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .interrupt_priority_select_o(prio_o), .processor_clock_control_o(clkc_o), .status_word_lo_o(sw_lo_o),
        .counter1_output_enable_o(oe_o), .irq_flags_o(irq_flags_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // a hang ends the run long before the simulator would
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [2:0] s, input logic [1:0] b, input logic [7:0] d);
        @(negedge ref_clk_i);
        addr_i = a;
        size_i = s;
        bit_sel_i = b;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge ref_clk_i);
        wr_i = 1'b0;
    endtask

    // answer lands exactly one cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [2:0] s, input logic [7:0] exp);
        @(negedge ref_clk_i);
        addr_i = a;
        size_i = s;
        rd_i = 1'b1;
        @(negedge ref_clk_i);
        rd_i = 1'b0;
        `CHK(rvalid_o, 1'b1)
        `CHK(rdata_o, exp)
    endtask

    task automatic pulse(input int which);
        @(negedge ref_clk_i);
        {gie_i, gdi_i, stop_i, halt_i} = 4'h8 >> which;
        @(negedge ref_clk_i);
        {gie_i, gdi_i, stop_i, halt_i} = 4'h0;
    endtask

    task automatic t_reset();
        rd(PIOR_OFS_EDGE0, PIOR_SZ_NIB, 8'h00);
        `CHK({prio_o, clkc_o, sw_lo_o, oe_o}, 13'h0000)
        `CHK(irq_flags_o, 20'h00000)
        $display("test reset done");
    endtask

    task automatic t_status();
        sw_hi_i = 4'ha;
        wr(PIOR_OFS_STATUS, PIOR_SZ_NIB, 2'h0, 8'h05);
        rd(PIOR_OFS_STATUS, PIOR_SZ_NIB, 8'h05);
        // byte write must leave the flags alone
        wr(PIOR_OFS_STATUS, PIOR_SZ_BYTE, 2'h0, 8'hff);
        rd(PIOR_OFS_STATUS, PIOR_SZ_BYTE, 8'ha5);
        wr(PIOR_OFS_STATUS, PIOR_SZ_BIT, 2'h3, 8'h01);
        `CHK(sw_lo_o, 4'hd)
        $display("test status word done");
    endtask

    task automatic t_edge();
        wr(PIOR_OFS_EDGE1, PIOR_SZ_NIB, 2'h0, 8'h0f);
        rd(PIOR_OFS_EDGE1, PIOR_SZ_NIB, 8'h01);
        wr(PIOR_OFS_EDGE2, PIOR_SZ_NIB, 2'h0, 8'h0f);
        rd(PIOR_OFS_EDGE2, PIOR_SZ_NIB, 8'h03);
        wr(PIOR_OFS_EDGE0, PIOR_SZ_NIB, 2'h0, 8'h0f);
        rd(PIOR_OFS_EDGE0, PIOR_SZ_NIB, 8'h0f);
        $display("test edge modes done");
    endtask

    task automatic t_instr();
        wr(PIOR_OFS_PRIO, PIOR_SZ_NIB, 2'h0, 8'h05);
        pulse(0);
        `CHK(prio_o, 4'hd)
        pulse(1);
        `CHK(prio_o, 4'h5)
        wr(PIOR_OFS_CLKCTL, PIOR_SZ_NIB, 2'h0, 8'h01);
        pulse(2);
        `CHK(clkc_o, 4'h9)
        pulse(3);
        rd(PIOR_OFS_CLKCTL, PIOR_SZ_NIB, 8'h0d);
        $display("test instructions done");
    endtask

    task automatic t_irq();
        wr(PIOR_OFS_IRQA, PIOR_SZ_BIT, 2'h2, 8'h01);
        `CHK(irq_flags_o, 20'h00004)
        wr(PIOR_OFS_IRQH, PIOR_SZ_BIT, 2'h1, 8'h01);
        rd(PIOR_OFS_IRQH, PIOR_SZ_NIB, 8'h02);
        // single-flag reads pick out one bit
        bit_sel_i = 2'h1;
        rd(PIOR_OFS_IRQH, PIOR_SZ_BIT, 8'h01);
        bit_sel_i = 2'h0;
        rd(PIOR_OFS_IRQH, PIOR_SZ_BIT, 8'h00);
        wr(PIOR_OFS_IRQA, PIOR_SZ_BIT, 2'h2, 8'h00);
        `CHK(irq_flags_o, 20'h20000)
        $display("test irq flags done");
    endtask

    task automatic t_oe();
        wr(PIOR_OFS_CNT1_OE, PIOR_SZ_NIB, 2'h0, 8'h01);
        `CHK(oe_o, 1'b0)
        wr(PIOR_OFS_CNT1_OE, PIOR_SZ_BIT, 2'h0, 8'h01);
        `CHK(oe_o, 1'b1)
        rd(PIOR_OFS_CNT1_OE, PIOR_SZ_NIB, 8'h00);
        wr(PIOR_OFS_CNT1_OE, PIOR_SZ_BIT, 2'h0, 8'h00);
        `CHK(oe_o, 1'b0)
        $display("test output enable done");
    endtask

    task automatic t_access();
        pd0_i = 4'h6;
        pd1_i = 4'h3;
        wr(PIOR_OFS_PDATA0, PIOR_SZ_NIB, 2'h0, 8'h09);
        rd(PIOR_OFS_PDATA0, PIOR_SZ_NIB, 8'h06);
        rd(PIOR_OFS_PDATA1, PIOR_SZ_NIB, 8'h03);
        wr(12'hfb1, PIOR_SZ_NIB, 2'h0, 8'h0f);
        rd(12'hfb1, PIOR_SZ_NIB, 8'h00);
        wr(PIOR_OFS_SBUS_CTRL, PIOR_SZ_NIB, 2'h0, 8'h0f);
        rd(PIOR_OFS_SBUS_CTRL, PIOR_SZ_NIB, 8'h00);
        wr(PIOR_OFS_SHIFT, PIOR_SZ_BYTE, 2'h0, 8'ha5);
        rd(PIOR_OFS_SHIFT, PIOR_SZ_BYTE, 8'ha5);
        // the answer stands one cycle only
        @(negedge ref_clk_i);
        `CHK(rvalid_o, 1'b0)
        `CHK(rdata_o, 8'h00)
        $display("test access kinds done");
    endtask

    initial begin
        reset_i = 1'b1;
        {wr_i, rd_i, gie_i, gdi_i, stop_i, halt_i} = 6'h00;
        addr_i = 12'h000;
        size_i = 3'h0;
        bit_sel_i = 2'h0;
        wdata_i = 8'h00;
        {pd0_i, pd1_i, sw_hi_i} = 12'h000;
        repeat (8) @(negedge ref_clk_i);
        reset_i = 1'b0;
        t_reset();
        t_status();
        t_edge();
        t_instr();
        t_irq();
        t_oe();
        t_access();
        finish_test();
    end
endmodule
